// File: core/cct_pkg.sv
package cct_pkg;

	// Register byte offsets
	localparam logic [7:0] CCT_OFS_CTRL     = 8'h00;
	localparam logic [7:0] CCT_OFS_COUNT    = 8'h04;
	localparam logic [7:0] CCT_OFS_STATUS   = 8'h08;
	localparam logic [7:0] CCT_OFS_MASK     = 8'h0C;
	localparam logic [7:0] CCT_OFS_VECTOR   = 8'h10;
	localparam logic [7:0] CCT_OFS_CH_BASE  = 8'h20;
	localparam logic [7:0] CCT_CH_STRIDE    = 8'h08;
	localparam logic [7:0] CCT_CH_CTL_SUB   = 8'h00;
	localparam logic [7:0] CCT_CH_CMP_SUB   = 8'h04;

	// Control register field positions
	localparam int CCT_CTRL_SRC_LSB = 8;
	localparam int CCT_CTRL_DIV_LSB = 6;
	localparam int CCT_CTRL_RUN_BIT = 4;
	localparam int CCT_CTRL_CLR_BIT = 2;
	localparam int CCT_CHCTL_MODE_BIT = 0;

	// Source selection codes
	localparam logic [1:0] CCT_SRC_EXT = 2'h0;
	localparam logic [1:0] CCT_SRC_AUX = 2'h1;
	localparam logic [1:0] CCT_SRC_SUB = 2'h2;
	localparam logic [1:0] CCT_SRC_ALT = 2'h3;

	// Vector encoding: zero when idle, steps of two per source
	localparam logic [7:0] CCT_VEC_NONE = 8'h00;
	localparam logic [7:0] CCT_VEC_STEP = 8'h02;

	// Reset values
	localparam logic [31:0] CCT_ZERO32 = 32'h0000_0000;
	localparam logic [2:0]  CCT_PRE_ZERO = 3'h0;

	// Live control fields as the timer logic sees them
	typedef struct packed {
		logic [1:0] src;    // Clock source select
		logic [1:0] div;    // Input divider field
		logic       run;    // Counter enable
	} cct_ctrl_t;

	// One staged register write crossing to the timer logic
	typedef struct packed {
		logic       clr;    // Counter clear request
		logic [7:0] addr;   // Target offset
		logic [31:0] data;  // Write data
		logic       valid;  // Write present
	} cct_wr_t;

endpackage : cct_pkg

// File: core/cct_channel.sv
`timescale 1ns/1ns
// One capture/compare channel
module cct_channel
	import cct_pkg::*;
#(
	parameter int CW = 16
) (
	// Clock and reset
	input  wire logic          clock,
	input  wire logic          rst_n,
	// Counter view
	input  wire logic [CW-1:0] timer_count,
	input  wire logic          count_adv,
	// Channel configuration
	input  wire logic          compare_mode,
	input  wire logic [CW-1:0] channel_compare_value,
	input  wire logic          cmp_write,
	// Capture input pin
	input  wire logic          cap_in,
	// Results
	output logic               event_q,
	output logic [CW-1:0]      cap_value_q
);

	logic cap_prev_q;   // Last capture pin level
	logic hit_hold_q;   // Counter still sits on a matched value
	logic skip_q;       // Next match is swallowed

	// Match hold: counter equals the compare value as it stood a cycle ago; tracked on
	// every cycle so a clear that moves the counter off a match drops it as well
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hit_hold_q <= 1'b0;
		end else begin
			hit_hold_q <= (timer_count == channel_compare_value);
		end
	end

	// Compare bumped while still matched loses the next match; capture mode cancels it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			skip_q <= 1'b0;
		end else if (!compare_mode) begin
			skip_q <= 1'b0; // [RQ7]
		end else if (count_adv) begin
			skip_q <= 1'b0;
		end else if (cmp_write && hit_hold_q) begin
			skip_q <= 1'b1; // [RQ6]
		end
	end

	// Event on compare match or capture edge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			event_q     <= 1'b0;
			cap_prev_q  <= 1'b0;
			cap_value_q <= '0;
		end else begin
			cap_prev_q <= cap_in;
			event_q    <= 1'b0;
			if (compare_mode) begin
				if (count_adv && (timer_count == channel_compare_value) && !skip_q) begin
					event_q <= 1'b1; // [RQ5]
				end
			end else if (cap_in && !cap_prev_q) begin
				event_q     <= 1'b1;
				cap_value_q <= timer_count;
			end
		end
	end

endmodule : cct_channel

// File: core/cct_timer.sv
`timescale 1ns/1ns
// Function
// RQ1: count from one of four selectable sources
// RQ2: reset or clear bit restarts the counter
// RQ3: first increment after clear ignores divider
// RQ4: later increments follow the divider field
// RQ5: compare match raises channel event
// RQ6: compare bumped during match loses next match
// RQ7: software uses capture mode while bumping compare
// RQ8: full control write clears interrupt vector
// RQ9: software rewrites control word after watchdog clear
// RQ10: reading vector clears the reported flag
// RQ11: register writes staged before reaching counter logic
module cct_timer
	import cct_pkg::*;
#(
	parameter int NCH = 3,   // Number of capture/compare channels
	parameter int CW  = 16   // Counter width
) (
	// Clock and reset
	input  wire logic           clock,
	input  wire logic           rst_n,
	// APB slave
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire logic [7:0]     paddr,
	input  wire logic [31:0]    pwdata,
	output logic [31:0]         prdata,
	output logic                pready,
	output logic                pslverr,
	// Timer clock sources, sampled as synchronous levels
	input  wire logic           external_timer_clock,
	input  wire logic           aux_clock,
	input  wire logic           sub_main_clock,
	input  wire logic           alternate_input_clock,
	// Capture inputs, one per channel
	input  wire logic [NCH-1:0] capture_in,
	// Interrupt
	output logic                irq
);

	localparam int NEV = NCH + 1;                    // Channel events plus overflow
	localparam int OVF = NCH;                        // Overflow status bit
	localparam logic [CW-1:0] CNT_ONE = CW'(1);

	// CPU-facing register state
	cct_ctrl_t          ctrl_q;                      // Control word as written
	logic [NEV-1:0]     status_q;                    // Sticky event flags
	logic [NEV-1:0]     mask_q;                      // Interrupt enables
	logic [NCH-1:0]     mode_q;                      // 1 = compare, 0 = capture
	logic [CW-1:0]      cmp_q [NCH];                 // Compare values as written
	cct_wr_t            wr_q;                        // Write staged for the timer side

	// Timer-side copies, updated one cycle after the bus write
	cct_ctrl_t          ctrl_t_q;                    // Live control fields
	logic [NCH-1:0]     mode_t_q;                    // Live channel modes
	logic [CW-1:0]      cmp_t_q [NCH];               // Live compare values
	logic [NCH-1:0]     cmp_wr_t_q;                  // Compare updated pulse

	// Counter state
	logic [CW-1:0]      timer_count_q;               // Running count
	logic [2:0]         pre_q;                       // Divider prescaler
	logic               first_q;                     // First increment still pending
	logic               src_prev_q;                  // Last selected source level
	logic               adv_q;                       // Counter moved last cycle
	logic               ovf_q;                       // Counter wrapped last cycle

	// Bus signals
	logic               access;                      // Access phase
	logic               done;                        // Completing edge
	logic               wr_done;                     // Write takes effect
	logic               rd_done;                     // Read completes
	logic               mapped;                      // Address decodes
	logic [31:0]        rdata_d;                     // Read mux
	logic [7:0]         ch_off;                      // Offset inside channel area
	logic [7:0]         ch_idx;                      // Channel number
	logic               ch_hit;                      // Address in channel area
	logic               ch_sub_cmp;                  // Channel compare word

	// Interrupt sources
	logic [NCH-1:0]     ch_event;                    // Channel event pulses
	logic [NEV-1:0]     ev_set;                      // All events this cycle
	logic [7:0]         vec_d;                       // Highest-priority vector
	logic [NEV-1:0]     vec_clr;                     // Flag the vector reports
	logic [NEV-1:0]     sw_clr;                      // Flags cleared this cycle

	// Source selection
	logic               src_lvl;                     // Selected source level
	logic               src_edge;                    // Rising edge of source
	logic [2:0]         pre_lim;                     // Divider terminal count

	// Bus side and timer side share one clock; the staging register below keeps
	// a control write from reaching the counter while it is half applied.
	// A write therefore lands on the counter one edge after its committing edge.
	// Transfer phase decode; pready comes one cycle into the access phase
	assign access  = psel && penable;
	assign done    = access && pready;
	assign wr_done = done && pwrite;
	assign rd_done = done && !pwrite;

	// Channel area decode
	assign ch_off     = paddr - CCT_OFS_CH_BASE;
	assign ch_idx     = ch_off / CCT_CH_STRIDE;
	assign ch_hit     = (paddr >= CCT_OFS_CH_BASE) && (ch_idx < 8'(NCH)) && (paddr[1:0] == 2'b00);
	assign ch_sub_cmp = ((ch_off % CCT_CH_STRIDE) == CCT_CH_CMP_SUB);

	// Read mux and address decode
	always_comb begin
		rdata_d = CCT_ZERO32;
		mapped  = 1'b1;
		unique case (paddr)
			CCT_OFS_CTRL: begin
				rdata_d[CCT_CTRL_SRC_LSB +: 2] = ctrl_q.src;
				rdata_d[CCT_CTRL_DIV_LSB +: 2] = ctrl_q.div;
				rdata_d[CCT_CTRL_RUN_BIT]      = ctrl_q.run;
			end
			CCT_OFS_COUNT:  rdata_d[CW-1:0]  = timer_count_q;
			CCT_OFS_STATUS: rdata_d[NEV-1:0] = status_q;
			CCT_OFS_MASK:   rdata_d[NEV-1:0] = mask_q;
			CCT_OFS_VECTOR: rdata_d[7:0]     = vec_d;
			default: begin
				if (ch_hit) begin
					// Channel words: mode bit or compare value
					if (ch_sub_cmp) begin
						rdata_d[CW-1:0] = cmp_q[ch_idx[$clog2(NCH+1)-1:0]];
					end else begin
						rdata_d[CCT_CHCTL_MODE_BIT] = mode_q[ch_idx[$clog2(NCH+1)-1:0]];
					end
				end else begin
					mapped = 1'b0;
				end
			end
		endcase
	end

	// APB answer: one wait state, data and error registered
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			prdata  <= CCT_ZERO32;
			pslverr <= 1'b0;
		end else begin
			pready  <= access && !pready;
			pslverr <= access && !pready && !mapped;
			if (access && !pready) begin
				prdata <= (!pwrite && mapped) ? rdata_d : CCT_ZERO32;
			end
		end
	end

	// Control word; every bus write is a whole-word write
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= '0;
		end else if (wr_done && paddr == CCT_OFS_CTRL) begin
			ctrl_q.src <= pwdata[CCT_CTRL_SRC_LSB +: 2];
			ctrl_q.div <= pwdata[CCT_CTRL_DIV_LSB +: 2];
			ctrl_q.run <= pwdata[CCT_CTRL_RUN_BIT];
		end
	end

	// Mask register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= '0;
		end else if (wr_done && paddr == CCT_OFS_MASK) begin
			mask_q <= pwdata[NEV-1:0];
		end
	end

	// Channel mode and compare registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= '0;
			for (int i = 0; i < NCH; i++) begin
				cmp_q[i] <= '0;
			end
		end else if (wr_done && ch_hit && mapped) begin
			for (int i = 0; i < NCH; i++) begin
				if (ch_idx == 8'(i)) begin
					if (ch_sub_cmp) begin
						cmp_q[i] <= pwdata[CW-1:0];
					end else begin
						mode_q[i] <= pwdata[CCT_CHCTL_MODE_BIT];
					end
				end
			end
		end
	end

	// Stage each completed write so the counter side acts a cycle later
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
		end else begin
			wr_q.valid <= wr_done && mapped;
			wr_q.addr  <= paddr;
			wr_q.data  <= pwdata;
			wr_q.clr   <= wr_done && (paddr == CCT_OFS_CTRL) && pwdata[CCT_CTRL_CLR_BIT];
		end
	end

	// Timer-side copies follow the bus-side registers a cycle later; counter never sees a half-applied write
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_t_q   <= '0;
			mode_t_q   <= '0;
			cmp_wr_t_q <= '0;
			for (int i = 0; i < NCH; i++) begin
				cmp_t_q[i] <= '0;
			end
		end else begin
			ctrl_t_q <= ctrl_q; // [RQ11]
			mode_t_q <= mode_q;
			for (int i = 0; i < NCH; i++) begin
				cmp_t_q[i]    <= cmp_q[i];
				cmp_wr_t_q[i] <= wr_q.valid && (wr_q.addr == CCT_OFS_CH_BASE + 8'(i) * CCT_CH_STRIDE
					+ CCT_CH_CMP_SUB);
			end
		end
	end

	// Sources are plain levels sampled on the system clock, so each must stay high
	// and low for at least one system clock or an edge is missed.
	// Trade-off: no synchroniser here, the pins are taken as already synchronous.
	// Source multiplexer
	always_comb begin
		unique case (ctrl_t_q.src)
			CCT_SRC_EXT: src_lvl = external_timer_clock; // [RQ1]
			CCT_SRC_AUX: src_lvl = aux_clock;
			CCT_SRC_SUB: src_lvl = sub_main_clock;
			CCT_SRC_ALT: src_lvl = alternate_input_clock;
		endcase
	end

	// Edge of the chosen source; a source switch can itself look like an edge
	assign src_edge = src_lvl && !src_prev_q;
	assign pre_lim  = 3'((4'h1 << ctrl_t_q.div) - 4'h1);

	// The divider counts source edges, not system clocks; first_q lets the first
	// edge after a clear through at once, whatever the divider holds.
	// The clear bit wins over a tick in the same cycle.
	// Counter with input divider and first-edge behaviour after a clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			timer_count_q <= '0;              // [RQ2]
			pre_q         <= CCT_PRE_ZERO;
			first_q       <= 1'b1;            // [RQ2]
			src_prev_q    <= 1'b0;
			adv_q         <= 1'b0;
			ovf_q         <= 1'b0;
		end else begin
			src_prev_q <= src_lvl;
			adv_q      <= 1'b0;
			ovf_q      <= 1'b0;
			if (wr_q.clr) begin
				// Clear bit: same starting state as reset
				timer_count_q <= '0;          // [RQ2]
				pre_q         <= CCT_PRE_ZERO;
				first_q       <= 1'b1;
			end else if (ctrl_t_q.run && src_edge) begin
				if (first_q || pre_q == pre_lim) begin
					// First edge after clear counts at once, divider notwithstanding
					timer_count_q <= timer_count_q + CNT_ONE; // [RQ3]
					pre_q         <= CCT_PRE_ZERO;            // [RQ4]
					first_q       <= 1'b0;
					adv_q         <= 1'b1;
					ovf_q         <= (timer_count_q == {CW{1'b1}});
				end else begin
					pre_q <= pre_q + 3'h1;    // [RQ4]
				end
			end
		end
	end

	// Capture/compare channels
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		cct_channel #(
			.CW(CW)
		) u_ch (
			.clock                 (clock),
			.rst_n                 (rst_n),
			.timer_count           (timer_count_q),
			.count_adv             (adv_q),
			.compare_mode          (mode_t_q[g]),
			.channel_compare_value (cmp_t_q[g]),
			.cmp_write             (cmp_wr_t_q[g]),
			.cap_in                (capture_in[g]),
			.event_q               (ch_event[g]),
			.cap_value_q           ()
		);
	end

	assign ev_set = {ovf_q, ch_event};

	// The vector is a pure function of the flags; the read that returns it also
	// clears the flag it names, so repeated reads walk down the pending list.
	// Vector: lowest channel first, overflow last
	always_comb begin
		vec_d   = CCT_VEC_NONE;
		vec_clr = '0;
		for (int i = NEV - 1; i >= 0; i--) begin
			if (status_q[i]) begin
				vec_d   = 8'(i + 1) * CCT_VEC_STEP;
				vec_clr = NEV'(1) << i;
			end
		end
	end

	// Software clears: write-one, vector read, or whole control write
	always_comb begin
		sw_clr = '0;
		if (wr_done && paddr == CCT_OFS_STATUS) begin
			sw_clr = pwdata[NEV-1:0];
		end
		if (wr_done && paddr == CCT_OFS_CTRL) begin
			sw_clr = {NEV{1'b1}};     // [RQ8]
		end
		if (rd_done && paddr == CCT_OFS_VECTOR) begin
			sw_clr = sw_clr | vec_clr; // [RQ10]
		end
	end

	// A write-one clear, a vector read and a control write all decode the one bus transfer,
	// so only one of them lands in a cycle; a new event in that cycle still sets its flag.
	// Sticky flags; an event in the clearing cycle survives
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			status_q <= '0;
		end else begin
			status_q <= (status_q & ~sw_clr) | ev_set;
		end
	end

	// The interrupt looks at next-cycle flags so it is not a cycle behind them,
	// while the output itself still comes straight from a flop.
	// Level interrupt from flops
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |((((status_q & ~sw_clr) | ev_set)) & mask_q);
		end
	end

endmodule : cct_timer

// File: sim/cct_timer_props.sv
`timescale 1ns/1ns
// Port-level checks of the timer block, bound into every instance
module cct_timer_props
	import cct_pkg::*;
#(
	parameter int NCH = 3,   // Channel count, taken from the design
	parameter int CW  = 16   // Counter width, taken from the design
) (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst_n,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Interrupt
	input wire logic        irq
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// Answer only after one waited access cycle
	chk_ready_wait: assert property (pready |-> psel && penable && $past(penable))
		else $error("pready came without a waited access cycle");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready stood longer than one cycle");
	chk_access_ready: assert property (psel && $rose(penable) |=> pready)
		else $error("pready missing in second access cycle");
	// Refusals come with the answer and carry no data
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr outside an answer");
	chk_err_zero: assert property (pslverr |-> prdata == CCT_ZERO32)
		else $error("refused read returned data");
	// Clear bit never reads back as set
	chk_clr_reads: assert property (pready && !pwrite && paddr == CCT_OFS_CTRL |-> !prdata[CCT_CTRL_CLR_BIT])
		else $error("clear bit read back as one");
	// Vector is even and within the source range
	chk_vec_range: assert property (pready && !pwrite && paddr == CCT_OFS_VECTOR |-> !prdata[0] && prdata <= 2 * (NCH + 1))
		else $error("vector value out of range");
	// A zero mask silences the interrupt within two cycles
	chk_mask_irq: assert property (psel && penable && pready && pwrite && paddr == CCT_OFS_MASK && pwdata == 0 |-> ##2 !irq)
		else $error("irq stayed high after mask cleared");

	// Main scenarios
	cov_refused: cover property (pslverr);
	cov_irq_rise: cover property ($rose(irq));
	cov_vec_read: cover property (pready && !pwrite && paddr == CCT_OFS_VECTOR && prdata != 0);
endmodule : cct_timer_props

bind cct_timer cct_timer_props #(.NCH(NCH), .CW(CW)) u_cct_timer_props (
	.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq)
);

// File: sim/cct_timer_bench.sv
`timescale 1ns/1ns
// Compare two values, count and report
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cct_timer_bench;
	import cct_pkg::*;
	localparam int NCH = 3;          // Channels in the device under test
	localparam int CW  = 4;          // Narrow counter so the wrap is reachable
	logic            clock;          // 125 MHz system clock
	logic            rst_n;          // Active low reset
	logic            psel;           // APB select
	logic            penable;        // APB enable
	logic            pwrite;         // APB direction
	logic [7:0]      paddr;          // APB byte address
	logic [31:0]     pwdata;         // APB write data
	logic [31:0]     prdata;         // APB read data
	logic            pready;         // APB answer
	logic            pslverr;        // APB refusal
	logic            irq;            // Interrupt level
	logic [3:0]      src_lv;         // Source levels, index is the source code
	logic [NCH-1:0]  cap_lv;         // Capture pins
	logic [31:0]     rd_q;           // Data of the last transfer
	logic            err_q;          // Refusal of the last transfer
	int              miscompares;    // Mismatches seen
	int              cmp_count;      // Comparisons made

	cct_timer #(.NCH(NCH), .CW(CW)) u_cct_timer (
		.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_timer_clock(src_lv[0]), .aux_clock(src_lv[1]), .sub_main_clock(src_lv[2]),
		.alternate_input_clock(src_lv[3]), .capture_in(cap_lv), .irq(irq)
	);

	// Free-running clock, 8 ns period
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// One APB transfer; waits for pready under a bound, never a fixed count
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) miscompares++;
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rd(input logic [7:0] a);
		apb(1'b0, a, CCT_ZERO32);
	endtask : rd

	// One rising edge on a source; all sources rest low so switching adds no tick
	task tick(input int i);
		@(posedge clock);
		src_lv[i] <= 1'b1;
		repeat (2) @(posedge clock);
		src_lv[i] <= 1'b0;
		repeat (3) @(posedge clock);
	endtask : tick

	// One capture pulse, then time for status to settle
	task cap(input int i);
		@(posedge clock);
		cap_lv[i] <= 1'b1;
		repeat (2) @(posedge clock);
		cap_lv[i] <= 1'b0;
		repeat (4) @(posedge clock);
	endtask : cap

	// Full control word: source, divider, run and clear
	function automatic logic [31:0] ctl(input logic [1:0] s, input logic [1:0] dv);
		return ({30'h0, s} << CCT_CTRL_SRC_LSB) | ({30'h0, dv} << CCT_CTRL_DIV_LSB)
			| (32'h1 << CCT_CTRL_RUN_BIT) | (32'h1 << CCT_CTRL_CLR_BIT);
	endfunction : ctl

	// Control write, then wait out the staging into the counter logic
	task restart(input logic [1:0] s, input logic [1:0] dv);
		wr(CCT_OFS_CTRL, ctl(s, dv));
		repeat (4) @(posedge clock);
	endtask : restart

	task t_regs;
		logic [7:0] ofs [6];
		ofs = '{CCT_OFS_CTRL, CCT_OFS_COUNT, CCT_OFS_STATUS, CCT_OFS_MASK, CCT_OFS_VECTOR, CCT_OFS_CH_BASE};
		for (int k = 0; k < 6; k++) begin
			rd(ofs[k]);
			`CHK(rd_q, CCT_ZERO32)
		end
		rd(8'hFC);
		`CHK(err_q, 1'b1)
		`CHK(rd_q, CCT_ZERO32)
		rd(8'h05);
		`CHK(err_q, 1'b1)
		wr(CCT_OFS_MASK, 32'h0000_000F);
		rd(CCT_OFS_MASK);
		`CHK(rd_q, 32'h0000_000F)
		wr(CCT_OFS_MASK, CCT_ZERO32);
		$display("t_regs done");
	endtask : t_regs

	// Every source with its own divider; first step ignores the divider
	task t_div;
		for (int s = 0; s < 4; s++) begin
			restart(2'(s), 2'(s));
			rd(CCT_OFS_COUNT);
			`CHK(rd_q, CCT_ZERO32)
			tick(s);
			rd(CCT_OFS_COUNT);
			`CHK(rd_q, 32'h0000_0001)
			tick((s + 1) % 4);
			for (int k = 1; k < (1 << s); k++) tick(s);
			rd(CCT_OFS_COUNT);
			`CHK(rd_q, 32'h0000_0001)
			tick(s);
			rd(CCT_OFS_COUNT);
			`CHK(rd_q, 32'h0000_0002)
		end
		$display("t_div done");
	endtask : t_div

	// Match, mask, vector read, sticky clear and control-write clear
	task t_cmp;
		wr(CCT_OFS_CH_BASE + CCT_CH_CMP_SUB, 32'h0000_0003);
		wr(CCT_OFS_CH_BASE, 32'h0000_0001);
		restart(CCT_SRC_EXT, 2'h0);
		repeat (3) tick(0);
		rd(CCT_OFS_STATUS);
		`CHK(rd_q, 32'h0000_0001)
		`CHK(irq, 1'b0)
		wr(CCT_OFS_MASK, 32'h0000_0001);
		repeat (3) @(posedge clock);
		`CHK(irq, 1'b1)
		rd(CCT_OFS_VECTOR);
		`CHK(rd_q, {24'h0, CCT_VEC_STEP})
		rd(CCT_OFS_STATUS);
		`CHK(rd_q, CCT_ZERO32)
		`CHK(irq, 1'b0)
		cap(1);
		wr(CCT_OFS_STATUS, CCT_ZERO32);
		rd(CCT_OFS_STATUS);
		`CHK(rd_q, 32'h0000_0002)
		wr(CCT_OFS_STATUS, 32'h0000_0002);
		rd(CCT_OFS_STATUS);
		`CHK(rd_q, CCT_ZERO32)
		cap(1);
		restart(CCT_SRC_EXT, 2'h0);
		rd(CCT_OFS_VECTOR);
		`CHK(rd_q, CCT_ZERO32)
		rd(CCT_OFS_STATUS);
		`CHK(rd_q, CCT_ZERO32)
		wr(CCT_OFS_MASK, CCT_ZERO32);
		$display("t_cmp done");
	endtask : t_cmp

	// Compare bumped on a live match loses the next one; capture mode avoids it
	task t_lost;
		wr(CCT_OFS_CH_BASE + CCT_CH_CMP_SUB, 32'h0000_0002);
		restart(CCT_SRC_EXT, 2'h0);
		repeat (2) tick(0);
		wr(CCT_OFS_STATUS, 32'h0000_0001);
		wr(CCT_OFS_CH_BASE + CCT_CH_CMP_SUB, 32'h0000_0003);
		repeat (4) @(posedge clock);
		tick(0);
		rd(CCT_OFS_STATUS);
		`CHK(rd_q, CCT_ZERO32)
		wr(CCT_OFS_CH_BASE, CCT_ZERO32);
		wr(CCT_OFS_CH_BASE + CCT_CH_CMP_SUB, 32'h0000_0004);
		wr(CCT_OFS_CH_BASE, 32'h0000_0001);
		repeat (4) @(posedge clock);
		tick(0);
		rd(CCT_OFS_STATUS);
		`CHK(rd_q, 32'h0000_0001)
		$display("t_lost done");
	endtask : t_lost

	// Counter wrap sets the overflow flag; vector reports the lowest pending flag first
	task t_ovf;
		wr(CCT_OFS_CH_BASE, CCT_ZERO32);
		restart(CCT_SRC_EXT, 2'h0);
		repeat (1 << CW) tick(0);
		rd(CCT_OFS_COUNT);
		`CHK(rd_q, CCT_ZERO32)
		cap(0);
		rd(CCT_OFS_STATUS);
		`CHK(rd_q, (32'h1 << NCH) | 32'h0000_0001)
		rd(CCT_OFS_VECTOR);
		`CHK(rd_q, {24'h0, CCT_VEC_STEP})
		rd(CCT_OFS_VECTOR);
		`CHK(rd_q, 32'(2 * (NCH + 1)))
		rd(CCT_OFS_STATUS);
		`CHK(rd_q, CCT_ZERO32)
		$display("t_ovf done");
	endtask : t_ovf

	// Single place where the run ends
	task print_verdict;
		$display("checks=%0d mismatches=%0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict

	// Main sequence
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = CCT_ZERO32;
		src_lv = 4'h0;
		cap_lv = '0;
		miscompares = 0;
		cmp_count = 0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		t_regs();
		t_div();
		t_cmp();
		t_lost();
		t_ovf();
		print_verdict();
	end

	// Watchdog at 20000 cycles, far beyond the several hundred cycles the tests need
	initial begin
		#160000;
		miscompares++;
		print_verdict();
	end
endmodule : cct_timer_bench
